// *** rtl/nsse_consts.vh ***
// Constants for the negate / subtract-with-carry / store execution block.
// Assumes an APB register window of 256 bytes and 16-bit instruction words.
`ifndef NSSE_CONSTS_VH
`define NSSE_CONSTS_VH

// Register byte offsets.
`define NSSE_OFS_INSTR      8'h00
`define NSSE_OFS_CTRL       8'h04
`define NSSE_OFS_FLAGS      8'h08
`define NSSE_OFS_STATUS     8'h0c
`define NSSE_OFS_MASK       8'h10
`define NSSE_OFS_GPR_BASE   8'h40

// Control register fields.
`define NSSE_CTRL_IN_COND   0

// Flag register fields.
`define NSSE_FLAG_N         31
`define NSSE_FLAG_Z         30
`define NSSE_FLAG_C         29
`define NSSE_FLAG_V         28

// Status and mask register fields.
`define NSSE_ST_DONE        0
`define NSSE_ST_FAULT       1
`define NSSE_ST_EVENT       2
`define NSSE_ST_UNDEF       3
`define NSSE_ST_BUSY        8
`define NSSE_ST_W           4

// Reset values.
`define NSSE_RST_CTRL       32'h0000_0000
`define NSSE_RST_FLAGS      4'h0
`define NSSE_RST_MASK       4'h0

// Instruction encodings.
`define NSSE_OPC_NEG        10'h109
`define NSSE_OPC_SBC        10'h106
`define NSSE_OPC_SEV        16'hbf40
`define NSSE_OPC_STM        5'h18
`define NSSE_OPC_STR_IMM    5'h0c
`define NSSE_OPC_STR_SP     5'h12
`define NSSE_OPC_STR_REG    7'h28
`define NSSE_OPC_STORE_BYTE_OP_IMM   5'h0e
`define NSSE_SP_INDEX       4'hd
`define NSSE_ADDR_STEP      32'h0000_0004

// Store sizes on the memory port.
`define NSSE_SIZE_BYTE      2'h0
`define NSSE_SIZE_WORD      2'h2

`endif

// *** rtl/nsse_exec.v ***
// Execution block for negate, subtract-with-carry, send-event and the stores.
// Assumes an APB master on pclk and a memory port on the same clock that
// holds mem_ready low until it can answer each store.
`timescale 1ns/1ps
`default_nettype none
`include "nsse_consts.vh"

// Function
// - negate is inverse operand plus one
// - negate sets flags only outside conditional block
// - borrow subtract adds inverse plus carry flag
// - borrow subtract updates all four flags
// - event hint signals every processor
// - without event support hint does nothing
// - multi store writes ascending words, step four
// - lowest register goes to lowest address
// - base written back plus four per register
// - non-lowest base in list stores arbitrary value
// - word store immediate: base plus offset, no writeback
// - first form offset five bits times four
// - second form uses stack pointer, eight bits
// - word store register: base plus offset register
// - byte store writes low eight bits
// - byte store offset unscaled, zero to 31
module nsse_exec #(
	parameter EVENT_SUPPORT = 1
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	output wire        irq,
	output reg         event_out,
	output reg         hard_fault_exc,
	output reg         mem_valid,
	input  wire        mem_ready,
	input  wire        mem_err,
	output reg  [31:0] mem_addr,
	output reg  [31:0] mem_wdata,
	output reg  [1:0]  mem_size
);

	////////////////////////////////////////////////////////////////////////
	// Helper functions.

	function [32:0] add_carry;
		input [31:0] a;
		input [31:0] b;
		input        cin;
		begin
			add_carry = {1'b0, a} + {1'b0, b} + {32'h0000_0000, cin};
		end
	endfunction

	function overflow_of;
		input [31:0] a;
		input [31:0] b;
		input [31:0] s;
		begin
			overflow_of = (a[31] == b[31]) && (s[31] != a[31]);
		end
	endfunction

	function [3:0] pop_count;
		input [7:0] list;
		integer     k;
		begin
			pop_count = 4'h0;
			for (k = 0; k < 8; k = k + 1)
				pop_count = pop_count + {3'h0, list[k]};
		end
	endfunction

	function [2:0] lowest_set;
		input [7:0] list;
		integer     k;
		begin
			lowest_set = 3'h0;
			for (k = 7; k >= 0; k = k - 1)
				if (list[k])
					lowest_set = k[2:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State.

	localparam [1:0] ST_IDLE   = 2'h0;
	localparam [1:0] ST_SINGLE = 2'h1;
	localparam [1:0] ST_MULTI  = 2'h2;

	reg  [1:0]  state_q;
	reg  [31:0] gpr_q [0:15];
	reg  [31:0] ctrl_q;
	reg  [3:0]  flags_q;
	reg  [3:0]  status_q;
	reg  [3:0]  mask_q;
	reg  [3:0]  rd_clr_q;
	reg  [7:0]  list_q;
	reg  [2:0]  base_q;
	reg  [31:0] base_val_q;
	reg  [31:0] addr_q;
	reg  [3:0]  count_q;

	////////////////////////////////////////////////////////////////////////
	// APB decode.

	wire        setup_ph  = psel & ~penable;
	wire        access_ph = psel & penable;
	wire        busy      = (state_q != ST_IDLE);
	wire        hit_gpr   = (paddr[7:6] == 2'h1);
	wire        hit_instr = (paddr == `NSSE_OFS_INSTR);
	wire        hit_ctrl  = (paddr == `NSSE_OFS_CTRL);
	wire        hit_flags = (paddr == `NSSE_OFS_FLAGS);
	wire        hit_stat  = (paddr == `NSSE_OFS_STATUS);
	wire        hit_mask  = (paddr == `NSSE_OFS_MASK);
	wire        mapped    = hit_gpr | hit_instr | hit_ctrl | hit_flags | hit_stat | hit_mask;
	wire        wr_block  = pwrite & busy & (hit_gpr | hit_instr | hit_flags);
	wire        wr_ok     = access_ph & pwrite & mapped & ~wr_block;

	assign pready  = 1'b1;
	assign pslverr = access_ph & (~mapped | wr_block);
	assign irq     = |(status_q & mask_q);

	reg [31:0] rd_mux;
	always @*
	begin
		rd_mux = 32'h0000_0000;
		if (hit_gpr)
			rd_mux = gpr_q[paddr[5:2]];
		else if (hit_ctrl)
			rd_mux = ctrl_q;
		else if (hit_flags)
			rd_mux = {flags_q, 28'h000_0000};
		else if (hit_stat)
			rd_mux = {23'h00_0000, busy, 4'h0, status_q};
		else if (hit_mask)
			rd_mux = {28'h000_0000, mask_q};
	end

	////////////////////////////////////////////////////////////////////////
	// Instruction decode of the word written to the instruction register.

	wire [15:0] ins       = pwdata[15:0];
	wire        go        = wr_ok & hit_instr;
	wire [3:0]  f_rd      = {1'b0, ins[2:0]};
	wire [3:0]  f_rn      = {1'b0, ins[5:3]};
	wire [3:0]  f_rm      = {1'b0, ins[8:6]};
	wire [31:0] op_n      = gpr_q[f_rn];
	wire [31:0] op_d      = gpr_q[f_rd];
	wire [31:0] op_m      = gpr_q[f_rm];
	wire        is_neg    = (ins[15:6] == `NSSE_OPC_NEG);
	wire        is_sbc    = (ins[15:6] == `NSSE_OPC_SBC);
	wire        is_sev    = (ins == `NSSE_OPC_SEV);
	wire        is_stm    = (ins[15:11] == `NSSE_OPC_STM);
	wire        is_str_i  = (ins[15:11] == `NSSE_OPC_STR_IMM);
	wire        is_str_sp = (ins[15:11] == `NSSE_OPC_STR_SP);
	wire        is_str_r  = (ins[15:9] == `NSSE_OPC_STR_REG);
	wire        is_store_byte_op_i = (ins[15:11] == `NSSE_OPC_STORE_BYTE_OP_IMM);
	wire        is_single = is_str_i | is_str_sp | is_str_r | is_store_byte_op_i;

	// Only an immediate of zero exists, so the addend is a zero word.
	wire [32:0] neg_sum   = add_carry(~op_n, 32'h0000_0000, 1'b1);
	wire        neg_v     = overflow_of(~op_n, 32'h0000_0000, neg_sum[31:0]);
	// The second operand is the f_rn field, bits 5:3, and the destination is Rdn.
	wire [32:0] sbc_sum   = add_carry(op_d, ~gpr_q[f_rn], flags_q[1]);
	wire        sbc_v     = overflow_of(op_d, ~gpr_q[f_rn], sbc_sum[31:0]);

	reg  [31:0] s_addr;
	reg  [31:0] s_data;
	reg  [1:0]  s_size;
	always @*
	begin
		s_addr = op_n + {25'h000_0000, ins[10:6], 2'h0};
		s_data = gpr_q[f_rd];
		s_size = `NSSE_SIZE_WORD;
		if (is_str_sp)
		begin
			s_addr = gpr_q[`NSSE_SP_INDEX] + {22'h00_0000, ins[7:0], 2'h0};
			s_data = gpr_q[{1'b0, ins[10:8]}];
		end
		else if (is_str_r)
			s_addr = op_n + op_m;
		else if (is_store_byte_op_i)
		begin
			s_addr = op_n + {27'h000_0000, ins[10:6]};
			s_data = {24'h00_0000, op_d[7:0]};
			s_size = `NSSE_SIZE_BYTE;
		end
	end

	wire [2:0]  low_idx  = lowest_set(list_q);
	wire        beat_end = mem_valid & mem_ready;

	////////////////////////////////////////////////////////////////////////
	// Execution, register file and status.

	reg  [3:0]  st_set;
	always @*
	begin
		st_set = 4'h0;
		if (go && is_sev && EVENT_SUPPORT != 0)
			st_set[`NSSE_ST_EVENT] = 1'b1;
		if (go && !(is_neg || is_sbc || is_sev || is_stm || is_single))
			st_set[`NSSE_ST_UNDEF] = 1'b1;
		if (go && (is_neg || is_sbc || is_sev))
			st_set[`NSSE_ST_DONE] = 1'b1;
		if (beat_end && mem_err)
			st_set[`NSSE_ST_FAULT] = 1'b1;
		if (beat_end && !mem_err && state_q == ST_SINGLE)
			st_set[`NSSE_ST_DONE] = 1'b1;
		if (state_q == ST_MULTI && list_q == 8'h00)
			st_set[`NSSE_ST_DONE] = 1'b1;
	end

	integer i;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q        <= ST_IDLE;
			for (i = 0; i < 16; i = i + 1)
				gpr_q[i] <= 32'h0000_0000;
			ctrl_q         <= `NSSE_RST_CTRL;
			flags_q        <= `NSSE_RST_FLAGS;
			status_q       <= 4'h0;
			mask_q         <= `NSSE_RST_MASK;
			rd_clr_q       <= 4'h0;
			list_q         <= 8'h00;
			base_q         <= 3'h0;
			base_val_q     <= 32'h0000_0000;
			addr_q         <= 32'h0000_0000;
			count_q        <= 4'h0;
			prdata         <= 32'h0000_0000;
			event_out      <= 1'b0;
			hard_fault_exc <= 1'b0;
			mem_valid      <= 1'b0;
			mem_addr       <= 32'h0000_0000;
			mem_wdata      <= 32'h0000_0000;
			mem_size       <= `NSSE_SIZE_WORD;
		end
		else
		begin
			event_out      <= 1'b0;
			hard_fault_exc <= 1'b0;

			// Read data is captured in the setup phase; a status read then
			// clears only the bits it returned, so a new event is kept.
			if (setup_ph)
			begin
				prdata   <= rd_mux;
				rd_clr_q <= (hit_stat & ~pwrite) ? status_q : 4'h0;
			end
			if (access_ph && !pwrite && hit_stat)
				status_q <= (status_q & ~rd_clr_q) | st_set;
			else
				status_q <= status_q | st_set;

			if (wr_ok && hit_gpr)
				gpr_q[paddr[5:2]] <= pwdata;
			if (wr_ok && hit_ctrl)
				ctrl_q <= pwdata;
			if (wr_ok && hit_flags)
				flags_q <= pwdata[31:28];
			if (wr_ok && hit_mask)
				mask_q <= pwdata[`NSSE_ST_W-1:0];

			if (go && is_neg)
			begin
				gpr_q[f_rd] <= neg_sum[31:0];
				if (!ctrl_q[`NSSE_CTRL_IN_COND])
					flags_q <= {neg_sum[31], neg_sum[31:0] == 32'h0000_0000,
						neg_sum[32], neg_v};
			end
			if (go && is_sbc)
			begin
				gpr_q[f_rd] <= sbc_sum[31:0];
				flags_q     <= {sbc_sum[31], sbc_sum[31:0] == 32'h0000_0000,
					sbc_sum[32], sbc_v};
			end
			if (go && is_sev && EVENT_SUPPORT != 0)
				event_out <= 1'b1;
			// With no event support the hint retires as a no-operation.
			if (go && is_sev && EVENT_SUPPORT == 0)
				event_out <= 1'b0;

			case (state_q)
				ST_IDLE:
				begin
					if (go && is_single)
					begin
						mem_valid <= 1'b1;
						mem_addr  <= s_addr;
						mem_wdata <= s_data;
						mem_size  <= s_size;
						state_q   <= ST_SINGLE;
					end
					else if (go && is_stm)
					begin
						list_q     <= ins[7:0];
						base_q     <= ins[10:8];
						base_val_q <= gpr_q[{1'b0, ins[10:8]}];
						addr_q     <= gpr_q[{1'b0, ins[10:8]}];
						count_q    <= pop_count(ins[7:0]);
						state_q    <= ST_MULTI;
					end
				end
				ST_SINGLE:
				begin
					if (beat_end)
					begin
						mem_valid <= 1'b0;
						state_q   <= ST_IDLE;
						if (mem_err)
							hard_fault_exc <= 1'b1;
					end
				end
				ST_MULTI:
				begin
					if (list_q == 8'h00)
					begin
						gpr_q[{1'b0, base_q}] <= base_val_q
							+ {26'h000_0000, count_q, 2'h0};
						state_q <= ST_IDLE;
					end
					else if (!mem_valid)
					begin
						// A base register that is not the lowest in the list may
						// store any value; the original base is what goes out.
						mem_valid <= 1'b1;
						mem_addr  <= addr_q;
						mem_wdata <= gpr_q[{1'b0, low_idx}];
						mem_size  <= `NSSE_SIZE_WORD;
					end
					else if (beat_end)
					begin
						mem_valid <= 1'b0;
						if (mem_err)
						begin
							hard_fault_exc <= 1'b1;
							state_q        <= ST_IDLE;
						end
						else
						begin
							list_q[low_idx] <= 1'b0;
							addr_q          <= addr_q + `NSSE_ADDR_STEP;
						end
					end
				end
				default:
				begin
					mem_valid <= 1'b0;
					state_q   <= ST_IDLE;
				end
			endcase
		end
	end

endmodule // nsse_exec

`default_nettype wire

// *** test/nsse_checker.sv ***
// Port checks for the store execution block.
// Bound to nsse_exec from the testbench; one clock, pclk.
`timescale 1ns/1ps
`default_nettype none
`include "nsse_consts.vh"
module nsse_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        event_out,
	input wire logic        hard_fault_exc,
	input wire logic        mem_valid,
	input wire logic        mem_ready,
	input wire logic        mem_err,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [1:0]  mem_size
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_wait;
		mem_valid && !mem_ready;
	endsequence
	sequence s_beat;
		mem_valid && mem_ready;
	endsequence
	sequence s_fail;
		mem_valid && mem_ready && mem_err;
	endsequence
	req_hold_a: assert property (s_wait |=> mem_valid && $stable(mem_addr)
		&& $stable(mem_wdata) && $stable(mem_size)) else $error("store request moved");
	beat_gap_a: assert property (s_beat |=> !mem_valid)
		else $error("no gap after beat");
	fault_raise_a: assert property (s_fail |=> hard_fault_exc)
		else $error("missing fault pulse");
	fault_cause_a: assert property (hard_fault_exc
		|-> $past(mem_valid) && $past(mem_ready) && $past(mem_err))
		else $error("fault without error beat");
	fault_pulse_a: assert property (hard_fault_exc |=> !hard_fault_exc)
		else $error("fault pulse too long");
	byte_lane_a: assert property (mem_valid && mem_size == `NSSE_SIZE_BYTE
		|-> mem_wdata[31:8] == 24'h0) else $error("byte store upper bits set");
	size_legal_a: assert property (mem_valid
		|-> mem_size == `NSSE_SIZE_BYTE || mem_size == `NSSE_SIZE_WORD) else $error("bad size");
	event_pulse_a: assert property (event_out |=> !event_out)
		else $error("event pulse too long");
	apb_ready_a: assert property (psel |-> pready && (penable || !pslverr))
		else $error("wait state or early error seen");
endmodule // nsse_checker
`default_nettype wire

// *** test/nsse_mem_model.sv ***
// Behavioural memory on the store port, answering after a varying delay.
// Same clock as the block; err_req turns each answer into an error.
`timescale 1ns/1ps
`default_nettype none
module nsse_mem_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        mem_valid,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	input  wire logic [1:0]  mem_size,
	input  wire logic        err_req,
	output var  logic        mem_ready,
	output wire logic        mem_err
);
	logic [31:0] aq[$];
	logic [31:0] dq[$];
	logic [1:0]  sq[$];
	logic [1:0]  wait_q;
	logic [1:0]  dly_q;
	// Outside an answer the error line follows wait_q[0] instead of staying low.
	assign mem_err = mem_ready ? err_req : wait_q[0];
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mem_ready <= 1'b0;
			wait_q <= 2'h0;
			dly_q <= 2'h0;
		end
		else if (mem_valid && mem_ready)
		begin
			mem_ready <= 1'b0;
			wait_q <= dly_q + 2'h1;
			dly_q <= dly_q + 2'h1;
			if (!err_req)
			begin
				aq.push_back(mem_addr);
				dq.push_back(mem_wdata);
				sq.push_back(mem_size);
			end
		end
		else if (mem_valid && wait_q == 2'h0)
			mem_ready <= 1'b1;
		else if (mem_valid)
			wait_q <= wait_q - 2'h1;
endmodule // nsse_mem_model
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench: APB driver, register model and store checks.
// Memory side is the behavioural model; the checker is bound below.
`timescale 1ns/1ps
`default_nettype none
`include "nsse_consts.vh"
module testbench;
	logic        pclk, presetn, psel, penable, pwrite, err_req, serr;
	logic        pready, pslverr, irq, event_out, hard_fault_exc;
	logic        mem_valid, mem_ready, mem_err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, mem_addr, mem_wdata, rdv, st;
	logic [31:0] g[16];
	logic [1:0]  mem_size;
	logic [3:0]  f;
	logic [35:0] r;
	integer      bad_count = 0, total_checks = 0, evn = 0, hfn = 0, irqn = 0;
	integer      i, k, seed = 32'h910022d8;
	nsse_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
		.prdata(prdata), .irq(irq), .event_out(event_out), .hard_fault_exc(hard_fault_exc),
		.mem_valid(mem_valid), .mem_ready(mem_ready), .mem_err(mem_err), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_size(mem_size));
	nsse_mem_model i_mem (.pclk(pclk), .presetn(presetn), .mem_valid(mem_valid),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size), .err_req(err_req),
		.mem_ready(mem_ready), .mem_err(mem_err));
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		if (event_out === 1'b1) evn++;
		if (hard_fault_exc === 1'b1) hfn++;
		if (irq === 1'b1) irqn++;
	end
	function automatic logic [35:0] addc(input logic [31:0] x, y, input logic ci);
		logic [32:0] s;
		s = {1'b0, x} + y + ci;
		return {s[31], s[31:0] == 0, s[32], x[31] == y[31] && s[31] != x[31], s[31:0]};
	endfunction
	task chk(input logic [31:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("ERROR %0t got %h want %h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdv = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wg(input integer n, input logic [31:0] v);
		g[n] = v;
		apb(1'b1, 8'h40 + {n[5:0], 2'b00}, v);
	endtask
	task cg(input integer n);
		apb(1'b0, 8'h40 + {n[5:0], 2'b00}, 0);
		chk(rdv, g[n]);
	endtask
	task cf;
		apb(1'b0, `NSSE_OFS_FLAGS, 0);
		chk({28'h0, rdv[31:28]}, {28'h0, f});
	endtask
	task run(input logic [15:0] ins);
		apb(1'b1, `NSSE_OFS_INSTR, {16'h0, ins});
		st = 0;
		do begin apb(1'b0, `NSSE_OFS_STATUS, 0); st |= rdv; end while (rdv[8] === 1'b1);
	endtask
	task beat(input logic [31:0] a, d, input logic [1:0] s);
		chk(i_mem.aq.pop_front(), a);
		chk(i_mem.dq.pop_front(), d);
		chk({30'h0, i_mem.sq.pop_front()}, {30'h0, s});
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#(40 * 40000);
		bad_count++;
		final_report;
	end
	initial
	begin
		{psel, penable, pwrite, err_req, presetn} = 5'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `NSSE_OFS_CTRL, 0);
		chk(rdv, `NSSE_RST_CTRL);
		apb(1'b0, 8'h20, 0);
		chk({31'h0, serr}, 1);
		f = `NSSE_RST_FLAGS;
		cf;
		for (i = 0; i < 16; i++) wg(i, $random(seed));
		for (i = 0; i < 16; i++) cg(i);
		$display("registers done");
		for (k = 0; k < 4; k++)
		begin
			wg(k, k == 0 ? 32'h0 : k == 1 ? 32'h8000_0000 : g[k]);
			apb(1'b1, `NSSE_OFS_CTRL, k[1]);
			r = addc(~g[k], 0, 1'b1);
			run({`NSSE_OPC_NEG, k[2:0], 3'd6});
			g[6] = r[31:0];
			if (!k[1]) f = r[35:32];
			cg(6);
			cf;
		end
		apb(1'b1, `NSSE_OFS_CTRL, 0);
		for (k = 0; k < 4; k++)
		begin
			f = {2'b00, k[0], 1'b0};
			apb(1'b1, `NSSE_OFS_FLAGS, {f, 28'h0});
			if (k == 3) wg(5, g[k]);
			r = addc(g[k], ~g[5], f[1]);
			run({`NSSE_OPC_SBC, 3'd5, k[2:0]});
			g[k] = r[31:0];
			f = r[35:32];
			cg(k);
			cf;
		end
		run(`NSSE_OPC_SEV);
		chk(evn, 1);
		chk({31'h0, st[2]}, 1);
		run(16'h0000);
		chk({31'h0, st[3]}, 1);
		chk({31'h0, st[0]}, 0);
		cg(0);
		$display("arithmetic done");
		run({`NSSE_OPC_STR_IMM, 5'd31, 3'd2, 3'd1});
		beat(g[2] + 124, g[1], `NSSE_SIZE_WORD);
		run({`NSSE_OPC_STR_SP, 3'd3, 8'hff});
		beat(g[13] + 1020, g[3], `NSSE_SIZE_WORD);
		run({`NSSE_OPC_STR_REG, 3'd4, 3'd5, 3'd6});
		beat(g[5] + g[4], g[6], `NSSE_SIZE_WORD);
		run({`NSSE_OPC_STORE_BYTE_OP_IMM, 5'd31, 3'd0, 3'd7});
		beat(g[0] + 31, {24'h0, g[7][7:0]}, `NSSE_SIZE_BYTE);
		cg(2);
		wg(1, g[1] & 32'hffff_fffc);
		run({`NSSE_OPC_STM, 3'd1, 8'h8e});
		i = 0;
		for (k = 0; k < 8; k++)
			if (k == 1 || k == 2 || k == 3 || k == 7)
			begin
				beat(g[1] + i, g[k], `NSSE_SIZE_WORD);
				i += 4;
			end
		g[1] = g[1] + i;
		cg(1);
		chk({31'h0, st[0]}, 1);
		chk(hfn, 0);
		$display("stores done");
		apb(1'b1, `NSSE_OFS_MASK, 2);
		err_req <= 1'b1;
		run({`NSSE_OPC_STM, 3'd1, 8'h8e});
		cg(1);
		chk({31'h0, st[1]}, 1);
		chk({31'h0, st[0]}, 0);
		chk({31'h0, irqn > 0}, 1);
		chk({31'h0, irq}, 0);
		apb(1'b1, `NSSE_OFS_MASK, 0);
		i = irqn;
		run({`NSSE_OPC_STR_REG, 3'd4, 3'd5, 3'd6});
		chk(irqn, i);
		chk(hfn, 2);
		err_req <= 1'b0;
		$display("faults done");
		final_report;
	end
endmodule // testbench
bind nsse_exec nsse_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr),
	.event_out(event_out), .hard_fault_exc(hard_fault_exc),
	.mem_valid(mem_valid), .mem_ready(mem_ready), .mem_err(mem_err),
	.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size));
`default_nettype wire
